// ==== hw/vop_channel_ctrl.sv ====
/*
 * Per-channel override control and pattern generator of a serial retimer:
 * register file, divider/charge-pump/capacitor/loop-filter overrides,
 * forced signal detect, output selection and PRBS-9/PRBS-31 generator,
 * with a 4-word FIFO in the output bit stream.
 * Assumes an 8-bit register port, one clock, and data/clock sources that
 * are already on that clock; status pins from the analog side are not.
 */
`timescale 1ns/1ps
`default_nettype none
module vop_channel_ctrl
   import vop_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   output logic [7:0] regRdData,
   // Analog status pins
   input wire logic signalPresent,
   input wire logic cdrLocked,
   input wire logic [2:0] detectedRateCode,
   // Output sources on this clock
   input wire logic rawData,
   input wire logic retimedData,
   input wire logic in_phase_vco_clock,
   input wire logic quadrature_vco_clock,
   input wire logic internalOscClock,
   // Analog controls
   output logic [2:0] vcoDivCode,
   output logic [4:0] vcoCapCount,
   output logic vcoCapOverride,
   output logic [4:0] loop_filter_voltage_source,
   output logic loopFilterOverride,
   output logic chargePumpEnable,
   output logic [1:0] chargePumpSetting,
   output logic vcoLockHold,
   output logic signalDetect,
   output logic channelEnable,
   output logic [2:0] outSelActive,
   // Channel output stream
   output logic chanBit,
   output logic chanValid,
   input wire logic chanReady
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] capCount;
      logic [7:0] overrideCtl;
      logic [7:0] patClk;
      logic [7:0] sdForce;
      logic [7:0] divSel;
      logic [7:0] chargePump;
      logic [7:0] outSel;
      logic [7:0] loopFilter;
      logic [7:0] patCfg;
      logic [4:0] syncA;
      logic [4:0] syncB;
      logic [4:0] syncC;
      logic [4:0] status;
      logic [30:0] lfsr;
      logic [3:0] bitCnt;
      logic [7:0] rdData;
      logic [2:0] oDiv;
      logic [4:0] oCap;
      logic oCapOv;
      logic [4:0] oLpf;
      logic oLpfOv;
      logic oCpEn;
      logic [1:0] oCp;
      logic oLockHold;
      logic oSd;
      logic oChanEn;
      logic [2:0] oSel;
   } vop_ctrl_state_t;

   vop_ctrl_state_t q, d;

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   // Divider code to bit-clock period minus one; codes above four are not
   // legal, they fall to the slowest ratio so the counter stays bounded
   function automatic logic [3:0] ratioMinusOne(input logic [2:0] code);
      case (code)
         3'h0: ratioMinusOne = 4'h0;
         3'h1: ratioMinusOne = 4'h1;
         3'h2: ratioMinusOne = 4'h3;
         3'h3: ratioMinusOne = 4'h7;
         default: ratioMinusOne = 4'hF;
      endcase
   endfunction

   // Register read decode
   function automatic logic [7:0] readReg(input vop_ctrl_state_t s,
                                          input logic [7:0] addr,
                                          input logic busy);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         OFS_CAP_COUNT: v = s.capCount;
         OFS_OVERRIDE: v = s.overrideCtl;
         OFS_PAT_CLK: v = s.patClk;
         OFS_SD_FORCE: v = s.sdForce;
         OFS_DIV_SEL: v = s.divSel;
         OFS_CHARGE_PUMP: v = s.chargePump;
         OFS_OUT_SEL: v = s.outSel;
         OFS_LOOP_FILTER: v = s.loopFilter;
         OFS_PAT_CFG: begin
            v = s.patCfg;
            v[PAT_BUSY_BIT] = busy;
            v[PAT_LOCK_BIT] = s.status[1];
         end
         default: v = 8'h00;
      endcase
      readReg = v;
   endfunction

   // ------------------------------------------------------------
   // Combinational signals
   // ------------------------------------------------------------
   logic present;
   logic locked;
   logic [2:0] autoCode;
   logic sdActive;
   logic [2:0] divCode;
   logic [2:0] selCode;
   logic cpDisabled;
   logic patEnabled;
   logic patLoaded;
   logic patRunning;
   logic prbsNew;
   logic prbsBit;
   logic srcBit;
   logic bitTick;
   logic fifoInReady;

   // Debounced status from the analog side
   assign present = q.status[0];
   assign locked = q.status[1];
   assign autoCode = q.status[4:2];

   // Forced detect on, forced off, or follow the pin
   always_comb begin
      if (q.sdForce[SD_FORCE_ON_BIT] && !q.sdForce[SD_FORCE_OFF_BIT]) begin
         sdActive = 1'b1;
      end else if (q.sdForce[SD_FORCE_OFF_BIT]) begin
         sdActive = 1'b0;
      end else begin
         sdActive = present;
      end
   end

   // Divider code: override field or the detected rate
   always_comb begin
      if (q.overrideCtl[OVR_DIV_BIT]) begin
         divCode = q.divSel[DIV_SEL_LSB +: 3];
      end else begin
         divCode = autoCode;
      end
   end

   // Output selection, default path mutes without detect and takes the field until locked
   always_comb begin
      if (q.overrideCtl[OVR_MUX_BIT]) begin
         selCode = q.outSel[OUT_SEL_LSB +: 3];
      end else if (!sdActive) begin
         selCode = SEL_MUTE;
      end else if (locked) begin
         selCode = SEL_RETIMED;
      end else begin
         selCode = q.outSel[OUT_SEL_LSB +: 3];
      end
   end

   // Charge pump off only with override bit and zero field
   assign cpDisabled = q.overrideCtl[OVR_CP_BIT]
                       && (q.chargePump[1:0] == 2'b00);

   // Generator controls
   assign patEnabled = q.outSel[PAT_EN_BIT];
   assign patLoaded = q.patCfg[PAT_LOAD_BIT];
   assign patRunning = patEnabled && patLoaded
                       && q.patClk[PAT_CLK_EN_BIT];

   // Feedback taps: only code two picks the long sequence
   always_comb begin
      if (q.patCfg[1:0] == SEQ_PRBS31) begin
         prbsNew = q.lfsr[30] ^ q.lfsr[27];
      end else begin
         prbsNew = q.lfsr[8] ^ q.lfsr[4];
      end
   end
   assign prbsBit = patEnabled & prbsNew;

   // Output multiplexer source
   always_comb begin
      case (selCode)
         SEL_RAW: srcBit = rawData;
         SEL_RETIMED: srcBit = retimedData;
         SEL_ICLK: srcBit = in_phase_vco_clock;
         SEL_QCLK: srcBit = quadrature_vco_clock
                            & q.overrideCtl[OVR_QCLK_BIT]
                            & q.outSel[QCLK_EN_BIT];
         SEL_PATTERN: srcBit = prbsBit;
         SEL_OSC: srcBit = internalOscClock;
         default: srcBit = 1'b0;
      endcase
   end

   // Bit clock: one tick per divide period, stalled by a full FIFO
   assign bitTick = sdActive && (q.bitCnt == ratioMinusOne(divCode));

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;

      // Register writes
      if (regWrEn) begin
         case (regAddr)
            OFS_CAP_COUNT: d.capCount = regWrData;
            OFS_OVERRIDE: d.overrideCtl = regWrData;
            OFS_PAT_CLK: d.patClk = regWrData;
            OFS_SD_FORCE: d.sdForce = regWrData;
            OFS_DIV_SEL: d.divSel = regWrData;
            OFS_CHARGE_PUMP: d.chargePump = regWrData;
            OFS_OUT_SEL: d.outSel = regWrData;
            OFS_LOOP_FILTER: d.loopFilter = regWrData;
            OFS_PAT_CFG: d.patCfg = regWrData;
            default: d.rdData = q.rdData;
         endcase
      end
      d.rdData = readReg(q, regAddr, patRunning);

      // Three-stage pin synchroniser; a change counts once stages agree
      d.syncA = {detectedRateCode, cdrLocked, signalPresent};
      d.syncB = q.syncA;
      d.syncC = q.syncB;
      d.status[1:0] = (~(q.syncB[1:0] ^ q.syncC[1:0]) & q.syncC[1:0])
                      | ((q.syncB[1:0] ^ q.syncC[1:0]) & q.status[1:0]);
      if (q.syncB[4:2] == q.syncC[4:2]) begin
         d.status[4:2] = q.syncC[4:2]; // Rate code moves as one word
      end

      // Bit-clock divider, held while the FIFO refuses a bit
      if (!sdActive) begin
         d.bitCnt = 4'h0;
      end else if (bitTick) begin
         if (fifoInReady) begin
            d.bitCnt = 4'h0;
         end
      end else begin
         d.bitCnt = q.bitCnt + 4'h1;
      end

      // Pattern generator register
      if (!patLoaded) begin
         d.lfsr = PRBS_SEED;
      end else if (patRunning && bitTick && fifoInReady) begin
         d.lfsr = {q.lfsr[29:0], prbsNew};
      end

      // Registered analog controls
      d.oDiv = divCode;
      d.oCap = q.capCount[4:0];
      d.oCapOv = q.overrideCtl[OVR_CAP_BIT];
      d.oLpf = q.loopFilter[4:0];
      d.oLpfOv = q.overrideCtl[OVR_LPF_BIT];
      d.oCpEn = !cpDisabled;
      d.oCp = q.chargePump[1:0];
      d.oLockHold = locked && !cpDisabled;
      d.oSd = sdActive;
      d.oChanEn = sdActive;
      d.oSel = selCode;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.overrideCtl <= RST_OVERRIDE;
         q.outSel <= RST_OUT_SEL;
         q.capCount <= RST_OTHER;
         q.lfsr <= PRBS_SEED;
         q.oCpEn <= 1'b1;
         q.oSel <= SEL_MUTE;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Output FIFO
   // ------------------------------------------------------------
   vop_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .inData(srcBit),
      .inValid(bitTick),
      .inReady(fifoInReady),
      .outData(chanBit),
      .outValid(chanValid),
      .outReady(chanReady)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign regRdData = q.rdData;
   assign vcoDivCode = q.oDiv;
   assign vcoCapCount = q.oCap;
   assign vcoCapOverride = q.oCapOv;
   assign loop_filter_voltage_source = q.oLpf;
   assign loopFilterOverride = q.oLpfOv;
   assign chargePumpEnable = q.oCpEn;
   assign chargePumpSetting = q.oCp;
   assign vcoLockHold = q.oLockHold;
   assign signalDetect = q.oSd;
   assign channelEnable = q.oChanEn;
   assign outSelActive = q.oSel;

endmodule
`default_nettype wire

// ==== hw/vop_pkg.sv ====
/*
 * Shared constants of the per-channel override and pattern-generator block:
 * register offsets, field positions, reset values, output select codes and
 * pattern generator seed.
 * Assumes an 8-bit register port with 8-bit addresses in front of the block.
 */
package vop_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CAP_COUNT = 8'h08;
   localparam logic [7:0] OFS_OVERRIDE = 8'h09;
   localparam logic [7:0] OFS_PAT_CLK = 8'h0D;
   localparam logic [7:0] OFS_SD_FORCE = 8'h14;
   localparam logic [7:0] OFS_DIV_SEL = 8'h18;
   localparam logic [7:0] OFS_CHARGE_PUMP = 8'h1B;
   localparam logic [7:0] OFS_OUT_SEL = 8'h1E;
   localparam logic [7:0] OFS_LOOP_FILTER = 8'h1F;
   localparam logic [7:0] OFS_PAT_CFG = 8'h30;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int OVR_DIV_BIT = 2;
   localparam int OVR_CP_BIT = 3;
   localparam int OVR_QCLK_BIT = 4;
   localparam int OVR_MUX_BIT = 5;
   localparam int OVR_LPF_BIT = 6;
   localparam int OVR_CAP_BIT = 7;
   localparam int PAT_CLK_EN_BIT = 5;
   localparam int SD_FORCE_ON_BIT = 7;
   localparam int SD_FORCE_OFF_BIT = 6;
   localparam int DIV_SEL_LSB = 4;
   localparam int OUT_SEL_LSB = 5;
   localparam int PAT_EN_BIT = 4;
   localparam int QCLK_EN_BIT = 0;
   localparam int PAT_LOAD_BIT = 3;
   localparam int PAT_BUSY_BIT = 7;
   localparam int PAT_LOCK_BIT = 6;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_OVERRIDE = 8'h00;
   localparam logic [7:0] RST_OUT_SEL = 8'hE0;
   localparam logic [7:0] RST_OTHER = 8'h00;

   // ------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------
   localparam logic [2:0] SEL_RAW = 3'h0;
   localparam logic [2:0] SEL_RETIMED = 3'h1;
   localparam logic [2:0] SEL_ICLK = 3'h2;
   localparam logic [2:0] SEL_QCLK = 3'h3;
   localparam logic [2:0] SEL_PATTERN = 3'h4;
   localparam logic [2:0] SEL_OSC = 3'h5;
   localparam logic [2:0] SEL_INVALID = 3'h6;
   localparam logic [2:0] SEL_MUTE = 3'h7;
   localparam logic [1:0] SEQ_PRBS9 = 2'h0;
   localparam logic [1:0] SEQ_PRBS31 = 2'h2;
   localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_WIDTH = 1;

endpackage

// ==== hw/vop_fifo.sv ====
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module vop_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Filling side
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // Draining side
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } vop_fifo_state_t;

   vop_fifo_state_t q, d;
   logic push;
   logic pop;

   // Handshakes
   assign inReady = (q.count != (AW+1)'(DEPTH));
   assign outValid = (q.count != '0);
   assign outData = q.mem[q.rdPtr];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   // Next state
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr = (q.wrPtr == AW'(DEPTH-1)) ? '0 : q.wrPtr + 1'b1;
      end
      if (pop) begin
         d.rdPtr = (q.rdPtr == AW'(DEPTH-1)) ? '0 : q.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         d.count = q.count + 1'b1;
      end else if (pop && !push) begin
         d.count = q.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// ==== test/vop_channel_ctrl_checker.sv ====
/*
 * Concurrent checks on the ports of the channel control block.
 * Assumes vop_pkg and the top module vop_channel_ctrl; bound below.
 */
`timescale 1ns/1ps
`default_nettype none
module vop_channel_ctrl_checker
   import vop_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   // Status pins
   input wire logic signalPresent,
   input wire logic cdrLocked,
   input wire logic [2:0] detectedRateCode,
   // Analog controls
   input wire logic [2:0] vcoDivCode,
   input wire logic [4:0] vcoCapCount,
   input wire logic vcoCapOverride,
   input wire logic [4:0] loop_filter_voltage_source,
   input wire logic loopFilterOverride,
   input wire logic chargePumpEnable,
   input wire logic [1:0] chargePumpSetting,
   input wire logic vcoLockHold,
   input wire logic signalDetect,
   input wire logic channelEnable,
   input wire logic [2:0] outSelActive,
   // Stream
   input wire logic chanBit,
   input wire logic chanValid,
   input wire logic chanReady
);
   // ------------------------------------------------------------
   // Shadow of the steering registers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ovr;
      logic [7:0] div;
      logic [7:0] sd;
      logic [7:0] sel;
   } vop_shadow_t;
   vop_shadow_t shadow_q;
   vop_shadow_t shadow_d;

   // Follow writes to the registers that steer the outputs
   always_comb begin
      shadow_d = shadow_q;
      if (regWrEn) begin
         case (regAddr)
            OFS_OVERRIDE: shadow_d.ovr = regWrData;
            OFS_DIV_SEL: shadow_d.div = regWrData;
            OFS_SD_FORCE: shadow_d.sd = regWrData;
            OFS_OUT_SEL: shadow_d.sel = regWrData;
            default: ;
         endcase
      end
   end

   // Register the shadow
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shadow_q <= {RST_OVERRIDE, RST_OTHER, RST_OTHER, RST_OUT_SEL};
      end else begin
         shadow_q <= shadow_d;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Settled spans for the automatic choices
   sequence s_autoQuiet;
      (!shadow_q.ovr[OVR_DIV_BIT] && $stable(detectedRateCode)) [*6];
   endsequence
   sequence s_lockQuiet;
      (!shadow_q.ovr[OVR_MUX_BIT] && shadow_q.sd == 8'h00 && signalPresent && cdrLocked) [*6];
   endsequence
   sequence s_pumpQuiet;
      (chargePumpEnable && signalPresent && cdrLocked) [*6];
   endsequence

   a_div_override: assert property (
      $past(shadow_q.ovr[OVR_DIV_BIT]) |-> vcoDivCode == $past(shadow_q.div[6:4]))
      else $error("divider code differs from forced field");
   a_div_auto: assert property (s_autoQuiet |-> vcoDivCode == detectedRateCode)
      else $error("divider code does not follow detected rate");
   a_cap_write: assert property (
      regWrEn && regAddr == OFS_CAP_COUNT |-> ##2 vcoCapCount == $past(regWrData[4:0], 2))
      else $error("capacitor count not taken from register");
   a_filter_write: assert property (
      regWrEn && regAddr == OFS_LOOP_FILTER
      |-> ##2 loop_filter_voltage_source == $past(regWrData[4:0], 2))
      else $error("loop filter value not taken from register");
   a_override_flags: assert property (
      vcoCapOverride == $past(shadow_q.ovr[OVR_CAP_BIT])
      && loopFilterOverride == $past(shadow_q.ovr[OVR_LPF_BIT]))
      else $error("override flags differ from register");
   a_pump_disable: assert property (
      chargePumpEnable == !($past(shadow_q.ovr[OVR_CP_BIT]) && chargePumpSetting == 2'h0))
      else $error("charge pump enable wrong");
   a_lock_hold: assert property (s_pumpQuiet |-> vcoLockHold)
      else $error("loop not held while locked");
   a_detect_force: assert property (
      $past(shadow_q.sd[7:6]) == 2'b10 |-> signalDetect && channelEnable)
      else $error("forced detect not active");
   a_enable_mirror: assert property (channelEnable == signalDetect)
      else $error("channel enable differs from detect");
   a_mux_override: assert property (
      $past(shadow_q.ovr[OVR_MUX_BIT]) |-> outSelActive == $past(shadow_q.sel[7:5]))
      else $error("forced output select not applied");
   a_retimed_locked: assert property (s_lockQuiet |-> outSelActive == SEL_RETIMED)
      else $error("locked channel not on retimed data");
   a_stream_hold: assert property (
      chanValid && !chanReady |=> chanValid && $stable(chanBit))
      else $error("stream bit dropped while stalled");
endmodule

bind vop_channel_ctrl vop_channel_ctrl_checker u_chk (
   .clk, .rstn, .regAddr, .regWrData, .regWrEn, .signalPresent, .cdrLocked,
   .detectedRateCode, .vcoDivCode, .vcoCapCount, .vcoCapOverride,
   .loop_filter_voltage_source, .loopFilterOverride, .chargePumpEnable,
   .chargePumpSetting, .vcoLockHold, .signalDetect, .channelEnable, .outSelActive,
   .chanBit, .chanValid, .chanReady
);
`default_nettype wire

// ==== test/vop_channel_ctrl_tb_top.sv ====
/*
 * Self-checking bench of the channel control block.
 * Assumes vop_pkg, the design and its checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module vop_channel_ctrl_tb_top
   import vop_pkg::*;
;
   logic clk, rstn, regWrEn, signalPresent, cdrLocked, rawData, retimedData;
   logic in_phase_vco_clock, quadrature_vco_clock, internalOscClock, chanReady;
   logic [7:0] regAddr, regWrData, regRdData, rdv, seq;
   logic [2:0] detectedRateCode, vcoDivCode, outSelActive;
   logic [4:0] vcoCapCount, loop_filter_voltage_source, srcs;
   logic [1:0] chargePumpSetting;
   logic vcoCapOverride, loopFilterOverride, chargePumpEnable, vcoLockHold;
   logic signalDetect, channelEnable, chanBit, chanValid, b;
   logic bits [100];
   logic [7:0] ofs [9];
   int nFail = 0;
   int checkCount = 0;
   int cycles = 0;
   int n;

   vop_channel_ctrl dut (
      .clk, .rstn, .regAddr, .regWrData, .regWrEn, .regRdData, .signalPresent,
      .cdrLocked, .detectedRateCode, .rawData, .retimedData, .in_phase_vco_clock,
      .quadrature_vco_clock, .internalOscClock, .vcoDivCode, .vcoCapCount,
      .vcoCapOverride, .loop_filter_voltage_source, .loopFilterOverride,
      .chargePumpEnable, .chargePumpSetting, .vcoLockHold, .signalDetect,
      .channelEnable, .outSelActive, .chanBit, .chanValid, .chanReady
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         nFail++;
         $display("[ERR] timeout expected end seen hang");
         results();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checkCount++;
      if (seen !== exp) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic waitN(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // One write, taken at the edge where the enable is high
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      waitN(1);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      waitN(1);
      regWrEn = 0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      waitN(1);
      regAddr = a;
      waitN(2);
      d = regRdData;
   endtask

   task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] e);
      rd(a, rdv);
      check(what, rdv, e);
   endtask

   // Read-modify-write keeps bits already set
   task automatic rmw(input logic [7:0] a, input logic [7:0] m);
      rd(a, rdv);
      wr(a, rdv | m);
   endtask

   // Take one bit off the stream; chanReady is held high
   task automatic getBit(output logic v);
      int k;
      k = 0;
      while (chanValid !== 1'b1 && k < 50) begin
         waitN(1);
         k++;
      end
      if (k == 50) check("stream valid", chanValid, 8'h01);
      v = chanBit;
      waitN(1);
   endtask

   // Any window of the sequence obeys its feedback recurrence
   task automatic prbsChk(input int tapA, input int tapB);
      int ones;
      ones = 0;
      repeat (20) getBit(b);
      for (int i = 0; i < 100; i++) begin
         getBit(bits[i]);
         if (bits[i] === 1'b1) ones++;
      end
      for (int i = tapA; i < 100; i++) begin
         check("prbs bit", bits[i], bits[i - tapA] ^ bits[i - tapB]);
      end
      check("prbs ones", ones > 10, 8'h01);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      {regAddr, regWrData, regWrEn, signalPresent, cdrLocked, detectedRateCode, rawData,
       retimedData, in_phase_vco_clock, quadrature_vco_clock, internalOscClock, chanReady} = '0;
      ofs = '{OFS_CAP_COUNT, OFS_OVERRIDE, OFS_PAT_CLK, OFS_SD_FORCE, OFS_DIV_SEL,
              OFS_CHARGE_PUMP, OFS_OUT_SEL, OFS_LOOP_FILTER, OFS_PAT_CFG};
      waitN(8);
      rstn = 1'b1;
      for (int i = 0; i < 9; i++) begin
         rdChk("reset value", ofs[i], (i == 6) ? RST_OUT_SEL : RST_OTHER);
      end
      for (int i = 0; i < 8; i++) begin
         wr(ofs[i], 8'h0B);
         rdChk("read back", ofs[i], 8'h0B);
         check("pump field", chargePumpSetting, (i == 5) ? 8'h03 : 8'h00);
         wr(ofs[i], (i == 6) ? RST_OUT_SEL : RST_OTHER);
      end
      wr(8'h05, 8'hFF);
      rdChk("unmapped", 8'h05, 8'h00);
      $display("test registers done");
      signalPresent = 1'b1;
      for (int c = 0; c < 5; c++) begin
         detectedRateCode = 3'(c);
         waitN(8);
         check("auto divider", vcoDivCode, 8'(c));
      end
      wr(OFS_OVERRIDE, 8'h0C);
      for (int c = 0; c < 5; c++) begin
         wr(OFS_DIV_SEL, 8'(c << 4));
         waitN(2);
         check("forced divider", vcoDivCode, 8'(c));
      end
      wr(OFS_OVERRIDE, 8'h00);
      wr(OFS_OUT_SEL, 8'h00);
      waitN(8);
      check("unlocked select", outSelActive, SEL_RAW);
      check("auto after cancel", vcoDivCode, 8'h04);
      cdrLocked = 1'b1;
      waitN(8);
      check("locked select", outSelActive, SEL_RETIMED);
      check("lock held", vcoLockHold, 8'h01);
      $display("test divider and default output done");
      signalPresent = 1'b0;
      cdrLocked = 1'b0;
      waitN(8);
      check("no input", channelEnable, 8'h00);
      wr(OFS_SD_FORCE, 8'h80);
      rmw(OFS_OVERRIDE, 8'h08);
      wr(OFS_CHARGE_PUMP, 8'h00);
      rmw(OFS_OVERRIDE, 8'h04);
      wr(OFS_DIV_SEL, 8'h00);
      rmw(OFS_OVERRIDE, 8'h80);
      wr(OFS_CAP_COUNT, 8'h08);
      rmw(OFS_OVERRIDE, 8'h40);
      wr(OFS_LOOP_FILTER, 8'h12);
      waitN(2);
      check("forced detect", channelEnable, 8'h01);
      check("pump off", chargePumpEnable, 8'h00);
      check("cap count", {vcoCapOverride, vcoCapCount}, 8'h28);
      check("loop filter", {loopFilterOverride, loop_filter_voltage_source}, 8'h32);
      rdChk("overrides kept", OFS_OVERRIDE, 8'hCC);
      $display("test free run done");
      chanReady = 1'b1;
      for (int s = 0; s < 2; s++) begin
         seq = {6'h00, (s == 1) ? SEQ_PRBS31 : SEQ_PRBS9};
         wr(OFS_PAT_CLK, 8'h00);
         wr(OFS_OUT_SEL, 8'h10);
         wr(OFS_PAT_CFG, 8'h00);
         wr(OFS_PAT_CFG, seq);
         wr(OFS_PAT_CFG, seq | 8'h08);
         rdChk("idle generator", OFS_PAT_CFG, seq | 8'h08);
         wr(OFS_PAT_CLK, 8'h20);
         rdChk("running generator", OFS_PAT_CFG, seq | 8'h88);
         rmw(OFS_OVERRIDE, 8'h20);
         wr(OFS_OUT_SEL, 8'h90);
         waitN(2);
         check("pattern select", outSelActive, SEL_PATTERN);
         if (s == 0) prbsChk(9, 5);
         else prbsChk(31, 28);
      end
      $display("test generator done");
      chanReady = 1'b0;
      waitN(10);
      check("fifo full", chanValid, 8'h01);
      wr(OFS_SD_FORCE, 8'h40);
      waitN(6);
      chanReady = 1'b1;
      n = 0;
      for (int k = 0; k < 12; k++) begin
         if (chanValid === 1'b1) n++;
         waitN(1);
      end
      check("fifo depth", 8'(n), 8'(FIFO_DEPTH));
      check("fifo empty", chanValid, 8'h00);
      $display("test buffer done");
      wr(OFS_SD_FORCE, 8'h80);
      rmw(OFS_OVERRIDE, 8'h10);
      for (int c = 0; c < 8; c++) begin
         if (c == 4) continue;
         srcs = (c < 4) ? 5'(5'h10 >> c) : (c == 5) ? 5'h01 : 5'h1F;
         {rawData, retimedData, in_phase_vco_clock, quadrature_vco_clock, internalOscClock} = srcs;
         wr(OFS_OUT_SEL, {3'(c), 5'h11});
         waitN(2);
         check("select code", outSelActive, 8'(c));
         repeat (8) getBit(b);
         check("source bit", b, (c < 6) ? 8'h01 : 8'h00);
      end
      $display("test output sources done");
      wr(OFS_OVERRIDE, 8'h00);
      waitN(2);
      check("overrides off", {vcoCapOverride, loopFilterOverride, chargePumpEnable}, 8'h01);
      $display("test cancel done");
      results();
   end
endmodule
`default_nettype wire
